/* File: ssp_pkg.sv */
// constants and types shared by both ends of the synchronous serial port
// assumes a single 50 MHz core clock on each end
package ssp_pkg;

	// special function register addresses
	localparam logic [7:0] SSP_CTRL_ADDR = 8'hbc;
	localparam logic [7:0] SSP_STAT_ADDR = 8'hbd;
	localparam logic [7:0] SSP_DATA_ADDR = 8'hbe;

	// serial_port_control fields
	localparam int CTRL_EN    = 7;
	localparam int CTRL_ROLE_SELECT  = 6;
	localparam int CTRL_CLOCK_IDLE_POLARITY  = 5;
	localparam int CTRL_CLOCK_SAMPLE_PHASE  = 4;
	localparam int CTRL_SELECT_INPUT_DISABLE = 3;
	localparam int CTRL_BIT_ORDER_SELECT  = 2;
	localparam int CTRL_RATE  = 0;

	// serial_port_status fields
	localparam int STAT_DONE = 7;
	localparam int STAT_WRITE_COLLISION_FLAG = 6;
	localparam int STAT_MODE_FAULT_FLAG = 5;
	localparam int STAT_OVF  = 4;
	localparam int STAT_RBF  = 3;
	localparam int STAT_BUSY = 2;

	// values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// sixteen clock edges make the eight bit periods of one byte
	localparam logic [3:0] LAST_EDGE = 4'hf;

	// far-end master half period, least time rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 20;
	localparam int EXT_HALF_NS   = 160;
	localparam logic [3:0] EXT_HALF_CYC =
		4'((EXT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {EXT_IDLE, EXT_LEAD, EXT_RUN, EXT_TRAIL} ssp_ext_state_t;

endpackage

/* File: ssp_if.sv */
// shared serial lines between the port and the far-end party
// resolves each line from the drivers' enables; undriven lines take pull levels
`timescale 1ns/1ps
interface ssp_if;
	logic devSckO;
	logic devSckOe;
	logic devMosiO;
	logic devMosiOe;
	logic devMisoO;
	logic devMisoOe;
	logic extSckO;
	logic extSckOe;
	logic extMosiO;
	logic extMosiOe;
	logic extMisoO;
	logic extMisoOe;
	logic extSsO;
	logic extSsOe;
	logic sck;
	logic mosi;
	logic miso;
	logic ssN;

	assign sck  = devSckOe ? devSckO : (extSckOe ? extSckO : 1'b0);
	assign mosi = devMosiOe ? devMosiO : (extMosiOe ? extMosiO : 1'b1);
	assign miso = devMisoOe ? devMisoO : (extMisoOe ? extMisoO : 1'b1);
	assign ssN  = extSsOe ? extSsO : 1'b1;

	modport dev (
		output devSckO, devSckOe, devMosiO, devMosiOe, devMisoO, devMisoOe,
		input  sck, mosi, miso, ssN
	);
	modport ext (
		output extSckO, extSckOe, extMosiO, extMosiOe, extMisoO, extMisoOe,
		output extSsO, extSsOe,
		input  sck, mosi, miso
	);
endinterface

/* File: ssp_device.sv */
// synchronous serial port of the microcontroller, master or slave, full duplex
// assumes processor special function register strobes on core_clk
// Overview of operation
// - role_select one is master, zero slave
// - master data write when idle starts shifting
// - master busy from write to eighth period end
// - byte end sets done, fills buffer, full
// - slave with select starts on low select
// - select disabled: port enable acts as selection
// - slave overrun keeps buffer, sets overrun flag
// - far master clock at most quarter system
// - slave busy follows select pin or enable
// - clock idles at the polarity bit level
// - phase picks first or second sample edge
// - rate field divides by 2,4,8,16 master
// - done requests interrupt, cleared by vector/zero
// - write while busy flags collision, is dropped
// - master low select faults, drops enable, role
// - bit order selects msb or lsb first
// - pin directions follow the master/slave role
// - both ends set clock type before enable
// - master selects only one slave at once
// - data read returns receive buffer contents
`timescale 1ns/1ps
module ssp_device
	import ssp_pkg::*;
(
	input  logic       core_clk,
	input  logic       rstn,
	input  logic [7:0] sfrAddr,
	input  logic       sfrWr,
	input  logic       sfrRd,
	input  logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	input  logic       intEnable,
	input  logic       intVectored,
	output logic       irqReq,
	ssp_if.dev         pins
);

	typedef struct packed {
		logic [7:0] ctrl;
		logic       done;
		logic       write_collision_flag;
		logic       mode_fault_flag;
		logic       ovf;
		logic       rbf;
		logic       mBusy;
		logic [7:0] rxBuf;
		logic [7:0] shreg;
		logic [3:0] edgeCnt;
		logic [3:0] divCnt;
		logic       inBit;
		logic       sckO;
		logic       sckOe;
		logic       mosiO;
		logic       mosiOe;
		logic       misoO;
		logic       misoOe;
		logic [1:0] sckSy;
		logic [1:0] mosiSy;
		logic [1:0] misoSy;
		logic [1:0] ssSy;
		logic       sckPrev;
		logic [7:0] rdata;
		logic       irq;
	} ssp_dev_state_t;

	ssp_dev_state_t q;
	ssp_dev_state_t d;

	logic       isMaster;
	logic       en;
	logic       clock_sample_phase;
	logic       bit_order_select;
	logic       select_input_disable;
	logic       ssLow;
	logic       slvSel;
	logic       busy;
	logic [3:0] halfCnt;
	logic       edgeEv;
	logic       sampleEdge;
	logic       pinIn;
	logic       nb;
	logic       wrCtrl;
	logic       wrStat;
	logic       wrData;
	logic       rdData;

	always_comb begin
		d = q;
		d.sckSy  = {q.sckSy[0], pins.sck};
		d.mosiSy = {q.mosiSy[0], pins.mosi};
		d.misoSy = {q.misoSy[0], pins.miso};
		d.ssSy   = {q.ssSy[0], pins.ssN};
		d.sckPrev = q.sckSy[1];

		isMaster = q.ctrl[CTRL_ROLE_SELECT];
		en       = q.ctrl[CTRL_EN];
		clock_sample_phase     = q.ctrl[CTRL_CLOCK_SAMPLE_PHASE];
		bit_order_select     = q.ctrl[CTRL_BIT_ORDER_SELECT];
		select_input_disable    = q.ctrl[CTRL_SELECT_INPUT_DISABLE];
		ssLow    = !q.ssSy[1];
		// slave selection by pin or by enable alone
		slvSel = !isMaster && (select_input_disable ? en : (en && ssLow));
		busy = isMaster ? q.mBusy : (select_input_disable ? en : ssLow);
		// half period of 1,2,4,8 cycles gives divide by 2,4,8,16
		halfCnt = 4'((4'h1 << q.ctrl[CTRL_RATE +: 2]) - 4'h1);

		wrCtrl = sfrWr && (sfrAddr == SSP_CTRL_ADDR);
		wrStat = sfrWr && (sfrAddr == SSP_STAT_ADDR);
		wrData = sfrWr && (sfrAddr == SSP_DATA_ADDR);
		rdData = sfrRd && (sfrAddr == SSP_DATA_ADDR);

		// software clears come first so that hardware sets below win
		if (wrCtrl) begin
			d.ctrl = sfrWdata;
		end
		if (wrStat) begin
			if (!sfrWdata[STAT_DONE]) begin
				d.done = 1'b0;
			end
			if (!sfrWdata[STAT_WRITE_COLLISION_FLAG]) begin
				d.write_collision_flag = 1'b0;
			end
			if (!sfrWdata[STAT_MODE_FAULT_FLAG]) begin
				d.mode_fault_flag = 1'b0;
			end
			if (!sfrWdata[STAT_OVF]) begin
				d.ovf = 1'b0;
			end
			if (!sfrWdata[STAT_RBF]) begin
				d.rbf = 1'b0;
			end
		end
		if (rdData) begin
			d.rbf = 1'b0;
			d.ovf = 1'b0;
		end
		if (intVectored) begin
			d.done = 1'b0;
		end

		if (wrData) begin
			if (busy) begin
				d.write_collision_flag = 1'b1;
			end else begin
				d.write_collision_flag = 1'b0;
				d.shreg = sfrWdata;
				if (isMaster && en) begin
					d.mBusy = 1'b1;
					d.edgeCnt = 4'h0;
					d.divCnt = halfCnt;
					d.inBit = 1'b0;
				end
			end
		end

		// a master sharing lines must not drive while another master selects it
		if (isMaster && !select_input_disable && ssLow) begin
			d.mode_fault_flag = 1'b1;
			d.ctrl[CTRL_EN] = 1'b0;
			d.ctrl[CTRL_ROLE_SELECT] = 1'b0;
			d.mBusy = 1'b0;
		end

		edgeEv = 1'b0;
		if (isMaster && q.mBusy) begin
			if (q.divCnt == 4'h0) begin
				edgeEv = 1'b1;
				d.divCnt = halfCnt;
			end else begin
				d.divCnt = q.divCnt - 4'h1;
			end
		end else if (slvSel && (q.sckSy[1] != q.sckPrev)) begin
			edgeEv = 1'b1;
		end
		if (!isMaster && !slvSel) begin
			d.edgeCnt = 4'h0;
		end

		pinIn = isMaster ? q.misoSy[1] : q.mosiSy[1];
		sampleEdge = (q.edgeCnt[0] == clock_sample_phase);
		nb = sampleEdge ? pinIn : q.inBit;
		if (edgeEv && d.mode_fault_flag == q.mode_fault_flag) begin
			d.inBit = nb;
			// first edge never shifts: the first bit is already on the line
			if ((!sampleEdge && q.edgeCnt != 4'h0) || q.edgeCnt == LAST_EDGE) begin
				d.shreg = bit_order_select ? {nb, q.shreg[7:1]} : {q.shreg[6:0], nb};
			end
			if (isMaster) begin
				d.sckO = ~q.sckO;
			end
			d.edgeCnt = q.edgeCnt + 4'h1;
			if (q.edgeCnt == LAST_EDGE) begin
				d.mBusy = 1'b0;
				d.done = 1'b1;
				if (!isMaster && d.rbf) begin
					d.ovf = 1'b1;
				end else begin
					d.rxBuf = d.shreg;
					d.rbf = 1'b1;
				end
			end
		end

		if (!d.mBusy) begin
			d.sckO = d.ctrl[CTRL_CLOCK_IDLE_POLARITY];
		end
		d.sckOe  = d.ctrl[CTRL_ROLE_SELECT] && d.ctrl[CTRL_EN];
		d.mosiOe = d.ctrl[CTRL_ROLE_SELECT] && d.ctrl[CTRL_EN];
		d.misoOe = slvSel;
		d.mosiO  = d.ctrl[CTRL_BIT_ORDER_SELECT] ? d.shreg[0] : d.shreg[7];
		d.misoO  = d.ctrl[CTRL_BIT_ORDER_SELECT] ? d.shreg[0] : d.shreg[7];

		if (sfrRd) begin
			if (sfrAddr == SSP_CTRL_ADDR) begin
				d.rdata = q.ctrl;
			end else if (sfrAddr == SSP_STAT_ADDR) begin
				d.rdata = {q.done, q.write_collision_flag, q.mode_fault_flag, q.ovf, q.rbf, busy, 2'b00};
			end else if (sfrAddr == SSP_DATA_ADDR) begin
				d.rdata = q.rxBuf;
			end else begin
				d.rdata = 8'h00;
			end
		end
		// one shared request line for all three events
		d.irq = intEnable && (d.done || d.write_collision_flag || d.mode_fault_flag);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.rxBuf <= DATA_RESET;
			q.shreg <= DATA_RESET;
			q.sckSy <= 2'b00;
			q.mosiSy <= 2'b11;
			q.misoSy <= 2'b11;
			q.ssSy <= 2'b11;
		end else begin
			q <= d;
		end
	end

	assign sfrRdata       = q.rdata;
	assign irqReq         = q.irq;
	assign pins.devSckO   = q.sckO;
	assign pins.devSckOe  = q.sckOe;
	assign pins.devMosiO  = q.mosiO;
	assign pins.devMosiOe = q.mosiOe;
	assign pins.devMisoO  = q.misoO;
	assign pins.devMisoOe = q.misoOe;

endmodule

/* File: ssp_partner.sv */
// far-end party on the serial lines: a master with one select, or a slave
// assumes its own 50 MHz core clock; user side gives bytes and clock type
`timescale 1ns/1ps
module ssp_partner
	import ssp_pkg::*;
(
	input  logic       core_clk,
	input  logic       rstn,
	input  logic       role,
	input  logic       clock_idle_polarity,
	input  logic       clock_sample_phase,
	input  logic       bit_order_select,
	input  logic       start,
	input  logic [7:0] txByte,
	output logic [7:0] rxByte,
	output logic       rxDone,
	output logic       busy,
	ssp_if.ext         pins
);

	typedef struct packed {
		ssp_ext_state_t st;
		logic [3:0]     cnt;
		logic [3:0]     edgeCnt;
		logic [7:0]     shreg;
		logic           inBit;
		logic           sckO;
		logic           ssO;
		logic           mOe;
		logic           sOe;
		logic           outBit;
		logic [1:0]     sckSy;
		logic [1:0]     dinSy;
		logic           sckPrev;
		logic [7:0]     rx;
		logic           done;
		logic           busy;
	} ssp_ext_reg_t;

	ssp_ext_reg_t q;
	ssp_ext_reg_t d;

	logic edgeEv;
	logic sampleEdge;
	logic nb;

	always_comb begin
		d = q;
		d.sckSy = {q.sckSy[0], pins.sck};
		d.dinSy = {q.dinSy[0], role ? pins.miso : pins.mosi};
		d.sckPrev = q.sckSy[1];
		d.done = 1'b0;
		d.mOe = role;
		d.sOe = !role;
		edgeEv = 1'b0;

		if (role) begin
			case (q.st)
				EXT_IDLE: begin
					d.sckO = clock_idle_polarity;
					if (start) begin
						d.shreg = txByte;
						d.ssO = 1'b0;
						d.busy = 1'b1;
						d.edgeCnt = 4'h0;
						d.cnt = EXT_HALF_CYC - 4'h1;
						d.st = EXT_LEAD;
					end
				end
				EXT_LEAD, EXT_TRAIL: begin
					if (q.cnt == 4'h0) begin
						d.cnt = EXT_HALF_CYC - 4'h1;
						d.st = (q.st == EXT_LEAD) ? EXT_RUN : EXT_IDLE;
						if (q.st == EXT_TRAIL) begin
							d.ssO = 1'b1;
							d.busy = 1'b0;
						end
					end else begin
						d.cnt = q.cnt - 4'h1;
					end
				end
				default: begin
					// half period of eight cycles keeps the clock under a quarter
					if (q.cnt == 4'h0) begin
						edgeEv = 1'b1;
						d.cnt = EXT_HALF_CYC - 4'h1;
						d.sckO = ~q.sckO;
						if (q.edgeCnt == LAST_EDGE) begin
							d.st = EXT_TRAIL;
						end
					end else begin
						d.cnt = q.cnt - 4'h1;
					end
				end
			endcase
		end else begin
			d.st = EXT_IDLE;
			d.ssO = 1'b1;
			d.busy = (q.edgeCnt != 4'h0);
			edgeEv = (q.sckSy[1] != q.sckPrev);
			if (start && q.edgeCnt == 4'h0) begin
				d.shreg = txByte;
			end
		end

		sampleEdge = (q.edgeCnt[0] == clock_sample_phase);
		nb = sampleEdge ? q.dinSy[1] : q.inBit;
		if (edgeEv) begin
			d.inBit = nb;
			if ((!sampleEdge && q.edgeCnt != 4'h0) || q.edgeCnt == LAST_EDGE) begin
				d.shreg = bit_order_select ? {nb, q.shreg[7:1]} : {q.shreg[6:0], nb};
			end
			d.edgeCnt = q.edgeCnt + 4'h1;
			if (q.edgeCnt == LAST_EDGE) begin
				d.rx = d.shreg;
				d.done = 1'b1;
			end
		end
		d.outBit = bit_order_select ? d.shreg[0] : d.shreg[7];
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.st <= EXT_IDLE;
			q.ssO <= 1'b1;
			q.sckSy <= 2'b00;
			q.dinSy <= 2'b11;
		end else begin
			q <= d;
		end
	end

	assign rxByte         = q.rx;
	assign rxDone         = q.done;
	assign busy           = q.busy;
	assign pins.extSckO   = q.sckO;
	assign pins.extSckOe  = q.mOe;
	assign pins.extMosiO  = q.outBit;
	assign pins.extMosiOe = q.mOe;
	assign pins.extSsO    = q.ssO;
	assign pins.extSsOe   = q.mOe;
	assign pins.extMisoO  = q.outBit;
	assign pins.extMisoOe = q.sOe;

endmodule

/* File: ssp_link_sva.sv */
// checker on the shared serial lines between the port and the far end
// assumes the interface signals are wired in by name beside the link
`timescale 1ns/1ps
module ssp_link_sva (
	input logic core_clk,
	input logic rstn,
	input logic devSckOe,
	input logic devMosiOe,
	input logic devMisoOe,
	input logic extMisoOe,
	input logic extSckO,
	input logic extSckOe,
	input logic extSsOe,
	input logic ssN
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_sel_start; $fell(ssN); endsequence
	sequence s_sel_held; !ssN [*8]; endsequence
	property p_dir_excl; !(devMosiOe && devMisoOe); endproperty
	a_dir_excl: assert property (p_dir_excl) else $error("mosi miso both out");
	property p_master_pair; devMosiOe == devSckOe; endproperty
	a_master_pair: assert property (p_master_pair) else $error("sck mosi split");
	property p_miso_one; !(devMisoOe && extMisoOe); endproperty
	a_miso_one: assert property (p_miso_one) else $error("miso two drivers");
	property p_far_slave; extMisoOe |-> !extSckOe; endproperty
	a_far_slave: assert property (p_far_slave) else $error("far slave drives sck");
	// sync delay plus register stage bounds the wait
	property p_mode_fault_flag; devSckOe && !ssN |-> ##[1:6] !devSckOe; endproperty
	a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("no fault release");
	property p_sel_end; extSsOe && ssN [*6] |-> !devMisoOe; endproperty
	a_sel_end: assert property (p_sel_end) else $error("miso out unselected");
	property p_ss_hold; s_sel_start |=> s_sel_held; endproperty
	a_ss_hold: assert property (p_ss_hold) else $error("select dropped early");
	property p_ext_rate; extSckOe && $changed(extSckO) |=> $stable(extSckO) [*3]; endproperty
	a_ext_rate: assert property (p_ext_rate) else $error("far sck too fast");
endmodule

/* File: tb_top.sv */
// testbench: port and far-end party joined over the shared lines
// assumes one 50 MHz clock; far-end reset kept apart to free the lines
`timescale 1ns/1ps
module tb_top;
	import ssp_pkg::*;
	logic       core_clk;
	logic       rstn;
	logic       pRstn;
	logic [7:0] sfrAddr;
	logic       sfrWr;
	logic       sfrRd;
	logic [7:0] sfrWdata;
	logic [7:0] sfrRdata;
	logic       intEnable;
	logic       intVectored;
	logic       irqReq;
	logic       role;
	logic       clock_sample_phase;
	logic       bit_order_select;
	logic       start;
	logic [7:0] txByte;
	logic [7:0] rxByte;
	logic       rxDone;
	logic       pBusy;
	int         n_fail;
	int         num_checks;
	int         r;
	ssp_if link ();
	ssp_device ssp_device_i (.core_clk(core_clk), .rstn(rstn), .sfrAddr(sfrAddr),
		.sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
		.intEnable(intEnable), .intVectored(intVectored), .irqReq(irqReq), .pins(link.dev));
	// far-end polarity fixed low: an idle-level change would look like an edge to it
	ssp_partner ssp_partner_i (.core_clk(core_clk), .rstn(pRstn), .role(role), .clock_idle_polarity(1'b0),
		.clock_sample_phase(clock_sample_phase), .bit_order_select(bit_order_select), .start(start), .txByte(txByte), .rxByte(rxByte),
		.rxDone(rxDone), .busy(pBusy), .pins(link.ext));
	ssp_link_sva ssp_link_sva_i (.core_clk(core_clk), .rstn(rstn),
		.devSckOe(link.devSckOe), .devMosiOe(link.devMosiOe), .devMisoOe(link.devMisoOe),
		.extMisoOe(link.extMisoOe), .extSckO(link.extSckO), .extSckOe(link.extSckOe),
		.extSsOe(link.extSsOe), .ssN(link.ssN));
	task automatic finish_test();
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		sfrAddr = a;
		sfrWdata = d;
		sfrWr = 1'b1;
		tick(1);
		sfrWr = 1'b0;
		tick(1);
	endtask
	task automatic rdc(string nm, logic [7:0] a, logic [7:0] exp);
		sfrAddr = a;
		sfrRd = 1'b1;
		tick(1);
		sfrRd = 1'b0;
		tick(1);
		chk(nm, sfrRdata, exp);
	endtask
	task automatic pulse_start(logic [7:0] b);
		txByte = b;
		start = 1'b1;
		tick(1);
		start = 1'b0;
	endtask
	task automatic wait_rx();
		int i;
		i = 0;
		while (rxDone !== 1'b1) begin
			tick(1);
			i++;
			if (i > 600) begin
				n_fail++;
				finish_test();
			end
		end
		tick(20);
	endtask
	// write starts the byte, then sck edges are counted and timed
	task automatic run_master(int half);
		int i;
		int n;
		int t0;
		int t1;
		logic last;
		sfrAddr = SSP_DATA_ADDR;
		sfrWdata = 8'h5a;
		sfrWr = 1'b1;
		n = 0;
		t0 = 0;
		t1 = 0;
		last = link.sck;
		for (i = 0; i < 400 && n < 16; i++) begin
			tick(1);
			sfrWr = 1'b0;
			if (link.sck !== last) begin
				n++;
				if (n == 1) t0 = i;
				if (n == 2) t1 = i;
			end
			last = link.sck;
		end
		chk("edges", 8'(n), 8'h10);
		chk("half", 8'(t1 - t0), 8'(half));
		if (n < 16) finish_test();
		tick(4);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		{rstn, pRstn, sfrWr, sfrRd, intVectored, role, clock_sample_phase, bit_order_select, start} = '0;
		{sfrAddr, sfrWdata, txByte} = '0;
		intEnable = 1'b1;
		n_fail = 0;
		num_checks = 0;
		repeat (10) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		tick(1);
		rdc("ctrl", SSP_CTRL_ADDR, 8'h00);
		rdc("stat", SSP_STAT_ADDR, 8'h00);
		rdc("data", SSP_DATA_ADDR, 8'h00);
		rdc("unmapped", 8'hbf, 8'h00);
		wr(SSP_CTRL_ADDR, 8'h8b);
		rdc("stat", SSP_STAT_ADDR, 8'h04);
		wr(SSP_CTRL_ADDR, 8'h83);
		rdc("stat", SSP_STAT_ADDR, 8'h00);
		wr(SSP_CTRL_ADDR, 8'he8);
		chk("idle sck", {7'h00, link.sck}, 8'h01);
		for (r = 0; r < 4; r++) begin
			wr(SSP_CTRL_ADDR, 8'hc8 | 8'(r));
			run_master(1 << r);
			rdc("stat", SSP_STAT_ADDR, 8'h88);
			chk("irq", {7'h00, irqReq}, 8'h01);
			intVectored = 1'b1;
			tick(1);
			intVectored = 1'b0;
			tick(2);
			rdc("stat", SSP_STAT_ADDR, 8'h08);
			rdc("data", SSP_DATA_ADDR, 8'hff);
			chk("irq", {7'h00, irqReq}, 8'h00);
		end
		pRstn = 1'b1;
		tick(2);
		for (r = 0; r < 4; r++) begin
			clock_sample_phase = r[0];
			bit_order_select = r[1];
			wr(SSP_CTRL_ADDR, 8'hcb | {3'h0, clock_sample_phase, 1'b0, bit_order_select, 2'h0});
			pulse_start(8'h3c + 8'(r));
			wr(SSP_DATA_ADDR, 8'ha1 + 8'(r));
			wr(SSP_DATA_ADDR, 8'h00);
			wait_rx();
			chk("far rx", rxByte, 8'ha1 + 8'(r));
			rdc("stat", SSP_STAT_ADDR, 8'hc8);
			rdc("data", SSP_DATA_ADDR, 8'h3c + 8'(r));
			wr(SSP_STAT_ADDR, 8'h00);
			rdc("stat", SSP_STAT_ADDR, 8'h00);
		end
		pRstn = 1'b0;
		role = 1'b1;
		clock_sample_phase = 1'b0;
		bit_order_select = 1'b0;
		tick(1);
		pRstn = 1'b1;
		wr(SSP_CTRL_ADDR, 8'h83);
		wr(SSP_DATA_ADDR, 8'h7e);
		pulse_start(8'h81);
		tick(40);
		rdc("stat", SSP_STAT_ADDR, 8'h04);
		wait_rx();
		chk("far rx", rxByte, 8'h7e);
		pulse_start(8'h42);
		wait_rx();
		rdc("stat", SSP_STAT_ADDR, 8'h98);
		rdc("data", SSP_DATA_ADDR, 8'h81);
		wr(SSP_STAT_ADDR, 8'h00);
		wr(SSP_CTRL_ADDR, 8'hc3);
		pulse_start(8'h00);
		wait_rx();
		rdc("ctrl", SSP_CTRL_ADDR, 8'h03);
		rdc("stat", SSP_STAT_ADDR, 8'h20);
		chk("irq", {7'h00, irqReq}, 8'h01);
		wr(SSP_STAT_ADDR, 8'h00);
		rdc("stat", SSP_STAT_ADDR, 8'h00);
		finish_test();
	end
endmodule
